// ===== host_model.sv
`timescale 1ns/1ps
module host_model
(
  output logic sdi,
  output logic sck,
  output logic store,
  output logic apply,
  output logic stop
);
  // ****************
  // Host link and command pins
  // ****************
  // All pins start low; shift clock stands still between frames
  initial
  begin
    sdi = 1'b0;
    sck = 1'b0;
    store = 1'b0;
    apply = 1'b0;
    stop = 1'b0;
  end
  // One word msb first at 125 ns; data moves on the falling edge
  task automatic send_word(input logic [15:0] w);
    #3;
    for (int i = 15; i >= 0; i--)
    begin
      sdi = w[i];
      #62.5 sck = 1'b1;
      #62.5 sck = 1'b0;
    end
    // Released data shows the inverse so a stale bit is never trusted
    sdi = ~w[0];
  endtask
  // Command pulse of 80 ns, then 80 ns quiet before the next one
  task automatic pulse(input int which);
    #3;
    case (which)
      0: store = 1'b1;
      1: apply = 1'b1;
      default: stop = 1'b1;
    endcase
    #80;
    store = 1'b0;
    apply = 1'b0;
    stop = 1'b0;
    #80;
  endtask
endmodule

// ===== led_pwm_ctrl.sv
`timescale 1ns/1ps
`include "led_pwm_map.svh"

module led_pwm_ctrl
  import led_pwm_pkg::*;
#(
  parameter int CHANNELS = `CHANNELS,
  parameter int WORD_W = `WORD_W,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
)
(
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic SERIAL_DATA_IN,
  input wire logic SHIFT_CLOCK,
  input wire logic STORE_WORD_COMMAND,
  input wire logic APPLY_DATA_COMMAND,
  input wire logic STOP_OUTPUT_COMMAND,
  input wire logic GRAYSCALE_COUNT_CLOCK,
  input wire opts_s OPTIONS,
  output logic SERIAL_DATA_OUTPUT,
  output logic [CHANNELS-1:0] CHANNEL_CURRENT_OUTPUT,
  output logic SECOND_SHORT_THRESHOLD_SEL,
  output logic PERIOD_RUNNING,
  output logic STORE_BUSY
);

  // ************************************************
  // Pin synchronisers and edge detection
  // ************************************************
  localparam int NSYNC = 6;

  logic [NSYNC-1:0] pins;             // Raw pins, all from outside the domain
  logic [NSYNC-1:0] sync1_reg;        // First stage, read only by the second
  logic [NSYNC-1:0] sync2_reg;        // Second stage, safe to use
  logic [NSYNC-1:0] prev_reg;         // Last value of the second stage
  logic sck_rise, sck_fall, gclk_rise;
  cmd_s cmd;

  assign pins = {SERIAL_DATA_IN, SHIFT_CLOCK, GRAYSCALE_COUNT_CLOCK,
                 STORE_WORD_COMMAND, APPLY_DATA_COMMAND, STOP_OUTPUT_COMMAND};
  assign sck_rise = sync2_reg[4] && !prev_reg[4];
  assign sck_fall = !sync2_reg[4] && prev_reg[4];
  assign gclk_rise = sync2_reg[3] && !prev_reg[3];
  assign cmd.store = sync2_reg[2] && !prev_reg[2];
  assign cmd.apply = sync2_reg[1] && !prev_reg[1];
  assign cmd.stop = sync2_reg[0] && !prev_reg[0];

  // Two flops per pin, then one more for edge finding
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end
    else
    begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // ************************************************
  // Helper functions
  // ************************************************

  // Resolution code to a mask of the counted bits
  function automatic logic [WORD_W-1:0] res_mask(input logic [1:0] res);
    logic [4:0] bits;
    bits = `RES_16_BITS;
    unique case (res)
      `RES_16: bits = `RES_16_BITS;
      `RES_14: bits = `RES_14_BITS;
      `RES_12: bits = `RES_12_BITS;
      `RES_10: bits = `RES_10_BITS;
    endcase
    res_mask = WORD_W'((17'h1_0000 >> (5'd16 - bits)) - 17'h1);
  endfunction

  // Divided form: segment number in low bits, offset in high bits, so
  // the on time is dealt out over the segments in turn instead of one block
  function automatic logic [WORD_W-1:0] divide_count(input logic [WORD_W-1:0] c,
                                                    input logic [1:0] res);
    logic [4:0] bits;
    logic [4:0] obits;
    logic [WORD_W-1:0] seg;
    logic [WORD_W-1:0] off;
    bits = `RES_16_BITS;
    unique case (res)
      `RES_16: bits = `RES_16_BITS;
      `RES_14: bits = `RES_14_BITS;
      `RES_12: bits = `RES_12_BITS;
      `RES_10: bits = `RES_10_BITS;
    endcase
    obits = bits - 5'(`SEG_BITS);
    seg = (c >> obits) & WORD_W'((1 << `SEG_BITS) - 1);
    off = c & WORD_W'((17'h1 << obits) - 17'h1);
    divide_count = WORD_W'(off << `SEG_BITS) | seg;
  endfunction

  // ************************************************
  // Word path FIFO
  // ************************************************
  logic push_pend_reg, push_pend_next;      // Word waiting for FIFO room
  logic [WORD_W-1:0] push_word_reg, push_word_next;
  logic fifo_in_ready;
  logic [WORD_W-1:0] fifo_out_data;
  logic fifo_out_valid;
  logic load_ready;

  word_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_word_fifo (
    .clk(CLK_SYS),
    .srst(SRST),
    .in_data(push_word_reg),
    .in_valid(push_pend_reg),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(load_ready)
  );

  // ************************************************
  // Control state
  // ************************************************
  logic [WORD_W-1:0] shift_reg, shift_next;          // Serial shift register
  logic serial_data_output_reg, serial_data_output_next;                         // Serial output bit
  logic apply_pend_reg, apply_pend_next;             // Apply waiting for drain
  logic [`IDX_W-1:0] idx_reg, idx_next;              // Next channel to load
  logic [WORD_W-1:0] data_reg [CHANNELS];            // Stored, not yet applied
  logic [WORD_W-1:0] data_next [CHANNELS];
  logic [WORD_W-1:0] snap_reg [CHANNELS];            // Applied, waiting for period end
  logic [WORD_W-1:0] snap_next [CHANNELS];
  logic snap_valid_reg, snap_valid_next;
  logic [WORD_W-1:0] live_reg [CHANNELS];            // Data driving the outputs
  logic [WORD_W-1:0] live_next [CHANNELS];
  logic [WORD_W-1:0] cnt_reg, cnt_next;              // Gray clock count in period
  run_state_e state_reg, state_next;
  logic apply_fire;
  logic period_end;

  // Stall the loader while a stop clears the channel index
  assign load_ready = !cmd.stop;
  // Apply acts only when every earlier word has reached its channel
  assign apply_fire = apply_pend_reg && !push_pend_reg && !fifo_out_valid;
  assign period_end = (state_reg == ST_RUN) && gclk_rise
                      && (cnt_reg == res_mask(OPTIONS.resolution));

  // Next values for the serial, loading and period logic
  always_comb
  begin
    shift_next = shift_reg;
    serial_data_output_next = serial_data_output_reg;
    push_pend_next = push_pend_reg;
    push_word_next = push_word_reg;
    apply_pend_next = apply_pend_reg;
    idx_next = idx_reg;
    data_next = data_reg;
    snap_next = snap_reg;
    snap_valid_next = snap_valid_reg;
    live_next = live_reg;
    cnt_next = cnt_reg;
    state_next = state_reg;

    // Input bits enter on the shift clock's rising edge
    if (sck_rise)
    begin
      shift_next = {shift_reg[WORD_W-2:0], sync2_reg[5]};
    end
    // Output follows the bit falling out, on the selected edge
    if (OPTIONS.serial_data_output_falling ? sck_fall : sck_rise)
    begin
      serial_data_output_next = shift_reg[WORD_W-1];
    end

    // Handing a word to the FIFO frees the slot
    if (push_pend_reg && fifo_in_ready)
    begin
      push_pend_next = 1'b0;
    end
    // Store and apply both capture the shifted word; a new one wins over the clear
    if (cmd.store || cmd.apply)
    begin
      push_pend_next = 1'b1;
      push_word_next = shift_reg;
    end
    // A word arriving while one is still waiting would overwrite it;
    // the host spacing keeps this from happening
    if (cmd.apply)
    begin
      apply_pend_next = 1'b1;
    end

    // Words land in channel order, wrapping after the last
    if (fifo_out_valid && load_ready)
    begin
      data_next[idx_reg] = fifo_out_data;
      idx_next = idx_reg + 1'b1;
    end

    // Period counting on the gray clock's rising edge
    if ((state_reg == ST_RUN) && gclk_rise)
    begin
      cnt_next = cnt_reg + 1'b1;
      if (period_end)
      begin
        cnt_next = '0;
        if (snap_valid_reg)
        begin
          // Only the latest applied data is held in the snapshot
          live_next = snap_reg;
          snap_valid_next = 1'b0;
        end
        else if (OPTIONS.one_shot)
        begin
          state_next = ST_IDLE;
        end
        else
        begin
          state_next = ST_RUN;
        end
      end
    end

    // Apply after the FIFO has drained
    if (apply_fire)
    begin
      apply_pend_next = cmd.apply;
      idx_next = '0;
      if (OPTIONS.async_update || (state_reg == ST_IDLE))
      begin
        // Abort the running period and restart with the new data
        live_next = data_reg;
        snap_valid_next = 1'b0;
        cnt_next = '0;
        state_next = ST_RUN;
      end
      else
      begin
        // Held until the running period ends; a later apply replaces it
        snap_next = data_reg;
        snap_valid_next = 1'b1;
      end
    end

    // Stop command turns outputs off and restarts channel order
    if (cmd.stop)
    begin
      state_next = ST_IDLE;
      cnt_next = '0;
      snap_valid_next = 1'b0;
      idx_next = '0;
    end
  end

  // Control registers
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      shift_reg <= '0;
      serial_data_output_reg <= 1'b0;
      push_pend_reg <= 1'b0;
      push_word_reg <= '0;
      apply_pend_reg <= 1'b0;
      idx_reg <= '0;
      snap_valid_reg <= 1'b0;
      cnt_reg <= '0;
      state_reg <= ST_IDLE;
      for (int i = 0; i < CHANNELS; i++)
      begin
        data_reg[i] <= '0;
        snap_reg[i] <= '0;
        live_reg[i] <= '0;
      end
    end
    else
    begin
      shift_reg <= shift_next;
      serial_data_output_reg <= serial_data_output_next;
      push_pend_reg <= push_pend_next;
      push_word_reg <= push_word_next;
      apply_pend_reg <= apply_pend_next;
      idx_reg <= idx_next;
      snap_valid_reg <= snap_valid_next;
      cnt_reg <= cnt_next;
      state_reg <= state_next;
      data_reg <= data_next;
      snap_reg <= snap_next;
      live_reg <= live_next;
    end
  end

  // ************************************************
  // Channel compare and stagger
  // ************************************************
  logic [CHANNELS-1:0] raw_next;                     // Undelayed on pattern
  logic [CHANNELS-1:0] hist_reg [CHANNELS];          // Pattern history, newest first
  logic [CHANNELS-1:0] hist_next [CHANNELS];
  logic [CHANNELS-1:0] out_next;
  logic [CHANNELS-1:0] out_reg;
  logic thresh_reg, thresh_next;

  // On pattern, delay line and output select
  always_comb
  begin
    logic [WORD_W-1:0] mask;
    logic [WORD_W-1:0] pos;
    mask = res_mask(OPTIONS.resolution);
    pos = OPTIONS.divided ? divide_count(cnt_reg, OPTIONS.resolution)
                          : cnt_reg;
    for (int k = 0; k < CHANNELS; k++)
    begin
      // On while the position is below the word: word counts of on time
      raw_next[k] = (state_reg == ST_RUN) && (pos < (live_reg[k] & mask));
    end
    hist_next[0] = raw_next;
    for (int k = 1; k < CHANNELS; k++)
    begin
      hist_next[k] = hist_reg[k-1];
    end
    // Channel k lags channel 0 by k steps; costs a short delay line but
    // keeps the simultaneous edges off the supply
    for (int k = 0; k < CHANNELS; k++)
    begin
      out_next[k] = OPTIONS.no_stagger ? raw_next[k]
                                       : hist_reg[k * `STAGGER_STEP][k];
    end
    thresh_next = OPTIONS.second_threshold;
  end

  // Output registers
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      out_reg <= '0;
      thresh_reg <= `OPT_DEFAULT;
      for (int k = 0; k < CHANNELS; k++)
      begin
        hist_reg[k] <= '0;
      end
    end
    else
    begin
      out_reg <= out_next;
      thresh_reg <= thresh_next;
      hist_reg <= hist_next;
    end
  end

  // Every output straight from a flop, except PERIOD_RUNNING, decoded from state_reg
  assign CHANNEL_CURRENT_OUTPUT = out_reg;
  assign SERIAL_DATA_OUTPUT = serial_data_output_reg;
  assign SECOND_SHORT_THRESHOLD_SEL = thresh_reg;
  assign PERIOD_RUNNING = (state_reg == ST_RUN);
  assign STORE_BUSY = push_pend_reg;

endmodule

// ===== led_pwm_ctrl_properties.sv
`timescale 1ns/1ps
module led_pwm_ctrl_properties
  import led_pwm_pkg::*;
#(
  parameter int CHANNELS = 16
)
(
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic SERIAL_DATA_IN,
  input wire logic SHIFT_CLOCK,
  input wire logic STORE_WORD_COMMAND,
  input wire logic APPLY_DATA_COMMAND,
  input wire logic STOP_OUTPUT_COMMAND,
  input wire logic GRAYSCALE_COUNT_CLOCK,
  input wire opts_s OPTIONS,
  input wire logic SERIAL_DATA_OUTPUT,
  input wire logic [CHANNELS-1:0] CHANNEL_CURRENT_OUTPUT,
  input wire logic SECOND_SHORT_THRESHOLD_SEL,
  input wire logic PERIOD_RUNNING,
  input wire logic STORE_BUSY
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SRST);
  // ****************
  // Pin edge ages
  // ****************
  logic sck_reg = 1'b0, sck_next; // Last shift clock
  logic app_reg = 1'b0, app_next; // Last apply pin
  logic [3:0] rise_reg = 4'hf, rise_next; // Cycles since shift clock rose
  logic [3:0] fall_reg = 4'hf, fall_next; // Cycles since shift clock fell
  logic [4:0] age_reg = 5'h1f, age_next; // Cycles since apply rose
  logic [4:0] idle_reg = 5'h00, idle_next; // Cycles spent idle
  // Counters saturate so a long quiet spell never wraps into a window
  always_comb
  begin
    sck_next = SHIFT_CLOCK;
    app_next = APPLY_DATA_COMMAND;
    rise_next = (SHIFT_CLOCK && !sck_reg) ? 4'h0 : rise_reg + {3'h0, rise_reg != 4'hf};
    fall_next = (!SHIFT_CLOCK && sck_reg) ? 4'h0 : fall_reg + {3'h0, fall_reg != 4'hf};
    age_next = (APPLY_DATA_COMMAND && !app_reg) ? 5'h00 : age_reg + {4'h0, age_reg != 5'h1f};
    idle_next = PERIOD_RUNNING ? 5'h00 : idle_reg + {4'h0, idle_reg != 5'h1f};
  end
  // Registers only
  always_ff @(posedge CLK_SYS)
  begin
    sck_reg <= sck_next;
    app_reg <= app_next;
    rise_reg <= rise_next;
    fall_reg <= fall_next;
    age_reg <= age_next;
    idle_reg <= idle_next;
  end
  // ****************
  // Properties
  // ****************
  property p_thr;
    !$past(SRST) && $stable(OPTIONS.second_threshold) |-> SECOND_SHORT_THRESHOLD_SEL == OPTIONS.second_threshold;
  endproperty
  a_thr: assert property (p_thr) else $error("threshold select differs from option");
  property p_serial_data_output_rise;
    $changed(SERIAL_DATA_OUTPUT) && !OPTIONS.serial_data_output_falling |-> rise_reg >= 4'h1 && rise_reg <= 4'h5;
  endproperty
  a_serial_data_output_rise: assert property (p_serial_data_output_rise) else $error("serial out moved off a rising edge");
  property p_serial_data_output_fall;
    $changed(SERIAL_DATA_OUTPUT) && OPTIONS.serial_data_output_falling |-> fall_reg >= 4'h1 && fall_reg <= 4'h5;
  endproperty
  a_serial_data_output_fall: assert property (p_serial_data_output_fall) else $error("serial out moved off a falling edge");
  property p_run;
    $rose(PERIOD_RUNNING) |-> age_reg >= 5'h03 && age_reg <= 5'h0e;
  endproperty
  a_run: assert property (p_run) else $error("period started without an apply");
  property p_idle;
    idle_reg == 5'h1f |-> CHANNEL_CURRENT_OUTPUT == '0;
  endproperty
  a_idle: assert property (p_idle) else $error("channel on while idle");
  property p_stop;
    $rose(STOP_OUTPUT_COMMAND) |-> ##[2:6] !PERIOD_RUNNING [*4];
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not halt periods");
  property p_store;
    $rose(STORE_WORD_COMMAND) |-> ##[2:7] STORE_BUSY;
  endproperty
  a_store: assert property (p_store) else $error("store did not capture a word");
  property p_apply_store;
    $rose(APPLY_DATA_COMMAND) |-> ##[2:7] STORE_BUSY;
  endproperty
  a_apply_store: assert property (p_apply_store) else $error("apply did not capture a word");
  property p_busy;
    $rose(STORE_BUSY) |-> ##[1:3] !STORE_BUSY;
  endproperty
  a_busy: assert property (p_busy) else $error("captured word not taken");
  property p_reset;
    disable iff (1'b0) SRST |=> CHANNEL_CURRENT_OUTPUT == '0 && !PERIOD_RUNNING && !STORE_BUSY;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  c_run: cover property ($rose(PERIOD_RUNNING));
  c_one_shot_end: cover property ($fell(PERIOD_RUNNING) && OPTIONS.one_shot);
  c_store: cover property ($rose(STORE_BUSY));
endmodule
bind led_pwm_ctrl led_pwm_ctrl_properties #(.CHANNELS(CHANNELS)) led_pwm_ctrl_properties_i
(
  .CLK_SYS(CLK_SYS), .SRST(SRST), .SERIAL_DATA_IN(SERIAL_DATA_IN), .SHIFT_CLOCK(SHIFT_CLOCK),
  .STORE_WORD_COMMAND(STORE_WORD_COMMAND), .APPLY_DATA_COMMAND(APPLY_DATA_COMMAND),
  .STOP_OUTPUT_COMMAND(STOP_OUTPUT_COMMAND), .GRAYSCALE_COUNT_CLOCK(GRAYSCALE_COUNT_CLOCK),
  .OPTIONS(OPTIONS), .SERIAL_DATA_OUTPUT(SERIAL_DATA_OUTPUT), .CHANNEL_CURRENT_OUTPUT(CHANNEL_CURRENT_OUTPUT),
  .SECOND_SHORT_THRESHOLD_SEL(SECOND_SHORT_THRESHOLD_SEL), .PERIOD_RUNNING(PERIOD_RUNNING),
  .STORE_BUSY(STORE_BUSY)
);

// ===== led_pwm_load_and_output_control_tb.sv
`timescale 1ns/1ps
`include "led_pwm_map.svh"
module led_pwm_load_and_output_control_tb
  import led_pwm_pkg::*;
();
  localparam int PER = 1 << `RES_10_BITS; // Gray clocks in one 10-bit period
  logic clk_sys, srst, gclk, sdi, sck, store, apply, stop, serial_data_output, thr_sel, running, busy;
  logic [15:0] chan; // Channel outputs
  opts_s opts; // Option bits
  int n_fail, cmp_count;
  led_pwm_ctrl led_pwm_ctrl_i
  (
    .CLK_SYS(clk_sys), .SRST(srst), .SERIAL_DATA_IN(sdi), .SHIFT_CLOCK(sck), .STORE_WORD_COMMAND(store),
    .APPLY_DATA_COMMAND(apply), .STOP_OUTPUT_COMMAND(stop), .GRAYSCALE_COUNT_CLOCK(gclk), .OPTIONS(opts),
    .SERIAL_DATA_OUTPUT(serial_data_output), .CHANNEL_CURRENT_OUTPUT(chan), .SECOND_SHORT_THRESHOLD_SEL(thr_sel),
    .PERIOD_RUNNING(running), .STORE_BUSY(busy)
  );
  host_model host_model_i (.sdi(sdi), .sck(sck), .store(store), .apply(apply), .stop(stop));
  // ****************
  // Helpers
  // ****************
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string what, input int exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // Distinct nonzero word per channel, inside the 10-bit range
  function automatic int wv(input int base, input int k);
    return (base + k * 61) % PER;
  endfunction
  // Gray clock held still between pulses, so the bench owns the count
  task automatic gray(input int n);
    repeat (n)
    begin
      gclk <= 1'b1;
      tick(4);
      gclk <= 1'b0;
      tick(4);
    end
  endtask
  task automatic load(input int base, input logic fast);
    for (int k = 0; k < 16; k++)
    begin
      host_model_i.send_word(16'(wv(base, k)));
      host_model_i.pulse((fast && k == 15) ? 1 : 0);
    end
    tick(20);
  endtask
  // Apply also stores into channel 0, so resend that channel's word
  task automatic apply0(input int base);
    host_model_i.send_word(16'(wv(base, 0)));
    host_model_i.pulse(1);
    tick(20);
  endtask
  // One full period from count 0: on count per channel, pulses on channel 0
  task automatic measure(input int base, input int segs0);
    int on_cnt [16];
    int segs;
    logic prev;
    segs = 0;
    prev = 1'b0;
    for (int k = 0; k < 16; k++)
      on_cnt[k] = 0;
    for (int p = 0; p < PER; p++)
    begin
      for (int k = 0; k < 16; k++)
        on_cnt[k] += (chan[k] === 1'b1);
      segs += (chan[0] === 1'b1 && !prev);
      prev = (chan[0] === 1'b1);
      gray(1);
    end
    for (int k = 0; k < 16; k++)
      check("channel on count", wv(base, k), on_cnt[k]);
    check("channel 0 pulses", segs0, segs);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_thresh();
    check("outputs after reset", 0, 32'(chan));
    opts.second_threshold <= 1'b1;
    tick(3);
    check("threshold select", 1, 32'(thr_sel));
    opts.second_threshold <= 1'b0;
    tick(3);
    check("threshold select", 0, 32'(thr_sel));
  endtask
  // Serial out carries the previous word's last bit after a full word
  task automatic t_serial_data_output();
    host_model_i.send_word(16'h00ff);
    host_model_i.send_word(16'h0000);
    tick(10);
    check("serial out", 1, 32'(serial_data_output));
    host_model_i.send_word(16'h0000);
    tick(10);
    check("serial out", 0, 32'(serial_data_output));
    // Falling mode shows the new msb; rising mode would still show 0 here
    opts.serial_data_output_falling <= 1'b1;
    host_model_i.send_word(16'h8000);
    tick(10);
    check("serial out falling", 1, 32'(serial_data_output));
    host_model_i.send_word(16'h0000);
    tick(10);
    check("serial out falling", 0, 32'(serial_data_output));
    opts.serial_data_output_falling <= 1'b0;
  endtask
  // Lag from channel 0 to channel 15 switching on at period start
  task automatic t_stagger(input logic nost, input int exp);
    int n;
    int d;
    opts.no_stagger <= nost;
    host_model_i.pulse(2);
    tick(20);
    host_model_i.send_word(16'(wv(8, 0)));
    fork
      host_model_i.pulse(1);
    join_none
    n = 0;
    d = 0;
    while (chan[0] !== 1'b1 && n < 100)
    begin
      @(negedge clk_sys);
      n++;
    end
    while (chan[15] !== 1'b1 && d < 50)
    begin
      @(negedge clk_sys);
      d++;
    end
    check("stagger lag", exp, d);
    tick(20);
  endtask
  // ****************
  // Main sequence
  // ****************
  initial
  begin
    srst = 1'b1;
    gclk = 1'b0;
    opts = '0;
    n_fail = 0;
    cmp_count = 0;
    tick(10);
    srst <= 1'b0;
    opts.resolution <= `RES_10;
    opts.no_stagger <= 1'b1;
    tick(5);
    t_thresh();
    t_serial_data_output();
    load(100, 1'b1);
    measure(100, 1);
    check("running in repeat", 1, 32'(running));
    load(200, 1'b0);
    measure(100, 1);
    gray(100);
    apply0(200);
    load(300, 1'b1);
    gray(PER - 100);
    measure(300, 1);
    opts.async_update <= 1'b1;
    gray(300);
    load(100, 1'b1);
    measure(100, 1);
    opts.one_shot <= 1'b1;
    apply0(100);
    gray(PER);
    tick(30);
    check("running after one shot", 0, 32'(running));
    gray(40);
    check("outputs after one shot", 0, 32'(chan));
    apply0(100);
    check("running after reapply", 1, 32'(running));
    opts.one_shot <= 1'b0;
    gray(50);
    host_model_i.pulse(2);
    tick(20);
    gray(20);
    check("running after stop", 0, 32'(running));
    check("outputs after stop", 0, 32'(chan));
    opts.divided <= 1'b1;
    opts.async_update <= 1'b0;
    load(8, 1'b1);
    measure(8, 8);
    opts.divided <= 1'b0;
    t_stagger(1'b0, 15 * `STAGGER_STEP);
    t_stagger(1'b1, 0);
    end_sim();
  end
  // Hang guard
  initial
  begin
    #990000;
    n_fail++;
    $display("Error watchdog expected finish seen hang");
    end_sim();
  end
endmodule

// ===== led_pwm_map.svh
`ifndef LED_PWM_MAP_SVH
`define LED_PWM_MAP_SVH

// Width of one gray word and of the serial shift register
`define WORD_W 16
// Number of driven channels
`define CHANNELS 16
// Bits of the channel index
`define IDX_W 4
// Divided form splits the period into 2**SEG_BITS segments (128)
`define SEG_BITS 7
// Resolution codes
`define RES_16 2'b00
`define RES_14 2'b01
`define RES_12 2'b10
`define RES_10 2'b11
// Resolutions in bits
`define RES_16_BITS 5'd16
`define RES_14_BITS 5'd14
`define RES_12_BITS 5'd12
`define RES_10_BITS 5'd10
// Depth of the word FIFO
`define FIFO_DEPTH 4
// System cycles of lag between neighbouring channels when staggered
`define STAGGER_STEP 1
// Option bit defaults
`define OPT_DEFAULT 1'b0

`endif

// ===== led_pwm_pkg.sv
package led_pwm_pkg;

  // Option bits set by the host's configuration
  typedef struct packed {
    logic [1:0] resolution;   // Selects 16/14/12/10-bit periods
    logic second_threshold;   // Short detect threshold select
    logic no_stagger;         // 1 switches all channels together
    logic serial_data_output_falling;       // 1 advances serial out on falling edge
    logic one_shot;           // 1 runs one period per apply
    logic async_update;       // 1 applies data at once
    logic divided;            // 1 spreads on time over segments
  } opts_s;

  // Command pulses after synchronising and edge detection
  typedef struct packed {
    logic store;
    logic apply;
    logic stop;
  } cmd_s;

  // Period sequencer states, Gray coded
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01
  } run_state_e;

endpackage

// ===== word_fifo.sv
`timescale 1ns/1ps
`include "led_pwm_map.svh"

module word_fifo
  import led_pwm_pkg::*;
#(
  parameter int WIDTH = `WORD_W,
  parameter int DEPTH = `FIFO_DEPTH
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  // ************************************************
  // Storage and pointers
  // ************************************************
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];  // Word storage
  logic [PW-1:0] wr_reg, wr_next;     // Write pointer
  logic [PW-1:0] rd_reg, rd_next;     // Read pointer
  logic [PW:0] cnt_reg, cnt_next;     // Words held
  logic push, pop;

  // Full and empty come straight from the count, so they never lie
  assign in_ready = (cnt_reg != DEPTH[PW:0]);
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rd_reg];

  // Next pointer and count values
  always_comb
  begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (push)
    begin
      wr_next = (wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
    end
    if (pop)
    begin
      rd_next = (rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop)
    begin
      cnt_next = cnt_reg + 1'b1;
    end
    else if (pop && !push)
    begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  // Pointer registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage needs no reset; a word is only read after it is written
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_reg[wr_reg] <= in_data;
    end
  end

endmodule
